// file: timer_module_common_core_bench.sv
// Self-checking bench for the timer core over APB.
// Assumes tmc_pkg and tmc_core; far side modelled by tmc_far_side.
`timescale 1ns/100ps
module timer_module_common_core_bench;
   import tmc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, high_tick, tbc_tick;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, ext_pin, ext_pin_alt, irq, err;
   logic [1:0]  alt_out, timer_output_pin, timer_pin_sel;
   logic [9:0]  c0, c1;
   int          n_mismatch, checked, highs;

   tmc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .internal_high_clock(high_tick), .timebase_clock(tbc_tick),
      .timer_ext_clock_pin(ext_pin), .ext_pin_alt(ext_pin_alt), .alt_func_out(alt_out),
      .timer_output_pin(timer_output_pin), .timer_pin_sel(timer_pin_sel), .irq(irq));
   tmc_far_side far (.pclk(pclk), .ext_pin(ext_pin), .alt_out(alt_out));

   // ----------------------------------------------------------------
   // Clock, reset, tick sources
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; high_tick = 1'b0; tbc_tick = 1'b0;
   end
   always #50 pclk = ~pclk;
   always @(posedge pclk) high_tick <= ~high_tick;

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_reg(rd, exp);
   endtask
   task automatic w16(input logic [7:0] lo, input logic [9:0] v);
      wr(lo, {24'h0, v[7:0]});
      wr(lo + 8'h04, {30'h0, v[9:8]});
   endtask
   // High byte first so the low byte is latched coherently
   task automatic r16(input logic [7:0] lo, output logic [9:0] v);
      apb(1'b0, lo + 8'h04, 32'h0);
      v[9:8] = rd[1:0];
      apb(1'b0, lo, 32'h0);
      v[7:0] = rd[7:0];
   endtask
   task automatic final_report;
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #(100 * 20000);
      n_mismatch++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      n_mismatch = 0;
      checked = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(OFF_PINEN, {30'h0, PINEN_RST});
      rdc(OFF_PDATA, {30'h0, PDATA_RST});
      chk_pin(timer_pin_sel, PINEN_RST);
      chk_pin(timer_output_pin, {alt_out[1], 1'b0});
      $display("test reset values done");

      w16(OFF_CMPA_L, 10'h2a5);
      r16(OFF_CMPA_L, c0);
      chk_reg({22'h0, c0}, 32'h2a5);
      $display("test byte pairing done");

      wr(OFF_CTRL1, 32'h10);
      wr(OFF_CTRL0, {27'h0, 1'b0, CS_EXT, 1'b1});
      r16(OFF_CNT_L, c0);
      far.pulses(3);
      r16(OFF_CNT_L, c1);
      chk_reg({22'h0, c1}, {22'h0, c0 + 10'd3});
      chk_pin({1'b0, ext_pin_alt}, 2'h0);
      far.drive(1'b1, 3);
      r16(OFF_CNT_L, c1);
      chk_reg({22'h0, c1}, {22'h0, c0 + 10'd4});
      wr(OFF_CTRL0, {27'h0, 1'b1, CS_EXT, 1'b1});
      far.drive(1'b0, 3);
      far.drive(1'b1, 3);
      r16(OFF_CNT_L, c1);
      chk_reg({22'h0, c1}, {22'h0, c0 + 10'd5});
      $display("test external clock done");

      wr(OFF_CTRL0, {27'h0, 1'b0, CS_RSVD, 1'b1});
      r16(OFF_CNT_L, c0);
      far.pulses(2);
      far.drive(1'b1, 3);
      r16(OFF_CNT_L, c1);
      chk_reg({22'h0, c1}, {22'h0, c0});
      chk_pin({1'b0, ext_pin_alt}, 2'h1);
      far.drive(1'b0, 2);
      $display("test reserved select done");

      wr(OFF_CTRL0, 32'h0);
      w16(OFF_CMPA_L, 10'h005);
      w16(OFF_CMPB_L, 10'h003);
      w16(OFF_CCRP_L, 10'h004);
      wr(OFF_CTRL1, {26'h0, 2'b01, MODE_CMP, ACT_HIGH});
      wr(OFF_PINEN, 32'h3);
      wr(OFF_PDATA, 32'h1);
      wr(OFF_IMASK, 32'h0);
      wr(OFF_ISTAT, 32'h7);
      wr(OFF_CTRL0, {27'h0, 1'b0, CS_SYS, 1'b1});
      repeat (20) @(posedge pclk);
      wr(OFF_CTRL0, 32'h0);
      rdc(OFF_ISTAT, 32'h7);
      chk_pin(timer_output_pin, 2'b01);
      chk_pin({1'b0, irq}, 2'h0);
      r16(OFF_CNT_L, c1);
      chk_reg({31'h0, c1 < 10'd6}, 32'h1);
      wr(OFF_IMASK, 32'h1 << IRQ_A);
      repeat (3) @(posedge pclk);
      chk_pin({1'b0, irq}, 2'h1);
      wr(OFF_ISTAT, 32'h1 << IRQ_A);
      rdc(OFF_ISTAT, (32'h1 << IRQ_B) | (32'h1 << IRQ_P));
      repeat (2) @(posedge pclk);
      chk_pin({1'b0, irq}, 2'h0);
      wr(OFF_CTRL1, {26'h0, 2'b01, MODE_CMP, ACT_LOW});
      wr(OFF_CTRL0, {27'h0, 1'b0, CS_SYS, 1'b1});
      repeat (20) @(posedge pclk);
      wr(OFF_CTRL0, 32'h0);
      chk_pin(timer_output_pin, 2'b10);
      wr(OFF_PINEN, 32'h1);
      repeat (3) @(posedge pclk);
      chk_pin(timer_output_pin, {alt_out[1], 1'b0});
      far.set_alt(2'h1);
      wr(OFF_PINEN, 32'h2);
      repeat (3) @(posedge pclk);
      chk_pin(timer_pin_sel, 2'h2);
      chk_pin(timer_output_pin, 2'b11);
      wr(OFF_PINEN, 32'h1);
      $display("test compare match done");

      // Duty from comparator A, period from P
      wr(OFF_CTRL1, {26'h0, 2'b00, MODE_PWM, ACT_NONE});
      for (int k = 0; k < 2; k++) begin
         w16(OFF_CMPA_L, k ? 10'h000 : 10'h3ff);
         wr(OFF_CTRL0, {27'h0, 1'b0, CS_SYS, 1'b1});
         repeat (4) @(posedge pclk);
         highs = 0;
         repeat (12) begin
            @(posedge pclk);
            highs += timer_output_pin[0];
         end
         wr(OFF_CTRL0, 32'h0);
         chk_reg(highs, k ? 32'd0 : 32'd12);
      end
      $display("test pwm done");

      wr(OFF_CTRL1, {26'h0, 2'b00, MODE_TIMER, ACT_NONE});
      w16(OFF_CCRP_L, 10'h3ff);
      wr(OFF_CTRL0, {27'h0, 1'b0, CS_TBC, 1'b1});
      r16(OFF_CNT_L, c0);
      repeat (5) begin
         @(posedge pclk);
         tbc_tick <= 1'b1;
         @(posedge pclk);
         tbc_tick <= 1'b0;
      end
      r16(OFF_CNT_L, c1);
      wr(OFF_CTRL0, 32'h0);
      chk_reg({22'h0, c1}, {22'h0, c0 + 10'd5});
      $display("test timebase clock done");

      apb(1'b0, 8'h38, 32'h0);
      chk_reg(rd, 32'h0);
      chk_pin({1'b0, err}, 2'h1);
      $display("test unmapped done");
      final_report();
   end
endmodule

// file: tmc_core.sv
// Timer core: counter, three comparators, output pins, APB registers.
// Assumes pins synchronous to pclk; high and timebase clocks arrive as ticks.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module tmc_core
   import tmc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        internal_high_clock,
   input  wire logic        timebase_clock,
   input  wire logic        timer_ext_clock_pin,
   output logic             ext_pin_alt,
   input  wire logic [1:0]  alt_func_out,
   output logic      [1:0]  timer_output_pin,
   output logic      [1:0]  timer_pin_sel,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic tmc_mapped(input logic [7:0] a);
      case (a)
         OFF_CTRL0, OFF_CTRL1, OFF_CNT_L, OFF_CNT_H, OFF_CMPA_L, OFF_CMPA_H,
         OFF_CMPB_L, OFF_CMPB_H, OFF_CCRP_L, OFF_CCRP_H, OFF_PINEN, OFF_PDATA,
         OFF_ISTAT, OFF_IMASK: tmc_mapped = 1'b1;
         default: tmc_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] tmc_hi(input logic [CNT_W-1:0] v);
      tmc_hi = {{(8-HI_W){1'b0}}, v[CNT_W-1:8]};
   endfunction

   tmc_state_t       s_r;
   tmc_state_t       s_nxt;
   tmc_ticks_t       ticks;
   logic             src_tick;
   logic             tick;
   logic             ext_edge;
   logic             acc_wr;
   logic             acc_rd;
   logic             match_a;
   logic             match_b;
   logic             match_p;
   logic             clr_hit;
   logic [CNT_W-1:0] duty;
   logic [2:0]       wclr;

   tmc_prescaler u_pre (
      .pclk      (pclk),
      .presetn   (presetn),
      .high_tick (internal_high_clock),
      .ticks     (ticks)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt  = s_r;
      acc_wr = psel & penable & pwrite;
      acc_rd = psel & penable & ~pwrite;
      wclr   = 3'h0;

      // Clock source selection
      s_nxt.ext_prev = timer_ext_clock_pin;
      ext_edge = s_r.timer_control_0.edge_fall ? (s_r.ext_prev & ~timer_ext_clock_pin)
                                               : (~s_r.ext_prev & timer_ext_clock_pin);
      case (s_r.timer_control_0.counter_clock_select)
         CS_SYS_DIV4: src_tick = ticks.sys_div4;
         CS_SYS:      src_tick = 1'b1;
         CS_HI_DIV4:  src_tick = ticks.hi_div4;
         CS_HI_DIV16: src_tick = ticks.hi_div16;
         CS_HI_DIV64: src_tick = ticks.hi_div64;
         CS_TBC:      src_tick = timebase_clock;
         CS_EXT:      src_tick = ext_edge;
         CS_RSVD:     src_tick = 1'b0;
         default:     src_tick = 1'b0;
      endcase
      // Pin goes to the alternate function only while the timer does not own it
      s_nxt.ext_alt = (s_r.timer_control_0.counter_clock_select == CS_EXT)
                      ? 1'b0 : timer_ext_clock_pin;
      tick = s_r.timer_control_0.run & src_tick;

      // Compare and count
      match_a = tick & (s_r.cnt == s_r.comparator_a_value);
      match_b = tick & (s_r.cnt == s_r.comparator_b_value);
      match_p = tick & (s_r.cnt == s_r.ccrp);
      if (s_r.ctrl1.mode == MODE_PWM) begin
         // One comparator fixes the period, the other the duty
         clr_hit = s_r.ctrl1.pwm_adj_period ? match_a : match_p;
         duty    = s_r.ctrl1.pwm_adj_period ? s_r.ccrp : s_r.comparator_a_value;
      end else begin
         clr_hit = s_r.ctrl1.clr_on_a ? match_a : match_p;
         duty    = s_r.comparator_a_value;
      end
      if (tick) begin
         s_nxt.cnt = clr_hit ? '0 : CNT_W'(s_r.cnt + 10'h001);
      end

      // Output generation
      case (s_r.ctrl1.mode)
         MODE_CMP: begin
            if (match_a) begin
               case (s_r.ctrl1.out_act)
                  ACT_LOW:    s_nxt.tm_out = 1'b0;
                  ACT_HIGH:   s_nxt.tm_out = 1'b1;
                  ACT_TOGGLE: s_nxt.tm_out = ~s_r.tm_out;
                  default:    s_nxt.tm_out = s_r.tm_out;
               endcase
            end
         end
         MODE_PWM: s_nxt.tm_out = (s_r.cnt < duty);
         default:  s_nxt.tm_out = s_r.tm_out;
      endcase
      for (int i = 0; i < 2; i++) begin
         // Data bit low inverts, so pin pairs can run complementary
         s_nxt.pin_out[i] = s_r.timer_pin_enable_0[i]
                            ? (s_r.tm_out ^ ~s_r.port_data[i])
                            : alt_func_out[i];
      end

      // Read data captured in the setup phase
      if (psel & ~penable & ~pwrite) begin
         case (paddr)
            OFF_CTRL0:  s_nxt.rdata = {3'h0, s_r.timer_control_0};
            OFF_CTRL1:  s_nxt.rdata = {2'h0, s_r.ctrl1};
            OFF_CNT_L:  s_nxt.rdata = s_r.cnt_buf;
            OFF_CNT_H:  s_nxt.rdata = tmc_hi(s_r.cnt);
            OFF_CMPA_L: s_nxt.rdata = s_r.cmpa_buf;
            OFF_CMPA_H: s_nxt.rdata = tmc_hi(s_r.comparator_a_value);
            OFF_CMPB_L: s_nxt.rdata = s_r.cmpb_buf;
            OFF_CMPB_H: s_nxt.rdata = tmc_hi(s_r.comparator_b_value);
            OFF_CCRP_L: s_nxt.rdata = s_r.ccrp_buf;
            OFF_CCRP_H: s_nxt.rdata = tmc_hi(s_r.ccrp);
            OFF_PINEN:  s_nxt.rdata = {6'h0, s_r.timer_pin_enable_0};
            OFF_PDATA:  s_nxt.rdata = {6'h0, s_r.port_data};
            OFF_ISTAT:  s_nxt.rdata = {5'h0, s_r.istat};
            OFF_IMASK:  s_nxt.rdata = {5'h0, s_r.imask};
            default:    s_nxt.rdata = 8'h00;
         endcase
      end

      // High byte read copies the live low byte into the buffer
      if (acc_rd) begin
         case (paddr)
            OFF_CNT_H:  s_nxt.cnt_buf  = s_r.cnt[7:0];
            OFF_CMPA_H: s_nxt.cmpa_buf = s_r.comparator_a_value[7:0];
            OFF_CMPB_H: s_nxt.cmpb_buf = s_r.comparator_b_value[7:0];
            OFF_CCRP_H: s_nxt.ccrp_buf = s_r.ccrp[7:0];
            default:    s_nxt.cnt_buf  = s_nxt.cnt_buf;
         endcase
      end

      if (acc_wr) begin
         case (paddr)
            OFF_CTRL0:  s_nxt.timer_control_0 = tmc_ctrl0_t'(pwdata[4:0]);
            OFF_CTRL1:  s_nxt.ctrl1 = tmc_ctrl1_t'(pwdata[5:0]);
            OFF_CMPA_L: s_nxt.cmpa_buf = pwdata[7:0];
            OFF_CMPA_H: s_nxt.comparator_a_value = {pwdata[HI_W-1:0], s_r.cmpa_buf};
            OFF_CMPB_L: s_nxt.cmpb_buf = pwdata[7:0];
            OFF_CMPB_H: s_nxt.comparator_b_value = {pwdata[HI_W-1:0], s_r.cmpb_buf};
            OFF_CCRP_L: s_nxt.ccrp_buf = pwdata[7:0];
            OFF_CCRP_H: s_nxt.ccrp = {pwdata[HI_W-1:0], s_r.ccrp_buf};
            OFF_PINEN:  s_nxt.timer_pin_enable_0 = pwdata[1:0];
            OFF_PDATA:  s_nxt.port_data = pwdata[1:0];
            OFF_ISTAT:  wclr = pwdata[2:0];
            OFF_IMASK:  s_nxt.imask = pwdata[2:0];
            default:    wclr = 3'h0;
         endcase
      end

      // Sticky flags: a new match beats a same-cycle clear
      s_nxt.istat = (s_r.istat & ~wclr) | {match_p, match_b, match_a};
      s_nxt.irq   = |(s_nxt.istat & s_nxt.imask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.timer_pin_enable_0 <= PINEN_RST;
         s_r.port_data <= PDATA_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata           = {24'h000000, s_r.rdata};
   assign pready           = 1'b1;
   assign pslverr          = psel & penable & ~tmc_mapped(paddr);
   assign ext_pin_alt      = s_r.ext_alt;
   assign timer_output_pin = s_r.pin_out;
   assign timer_pin_sel    = s_r.timer_pin_enable_0;
   assign irq              = s_r.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rsvd_stops;
      (s_r.timer_control_0.counter_clock_select == CS_RSVD) |=> (s_r.cnt == $past(s_r.cnt));
   endproperty
   a_rsvd_stops: assert property (p_rsvd_stops) else $error("counter moved on reserved clock");

   property p_step;
      (tick && !clr_hit) |=> (s_r.cnt == CNT_W'($past(s_r.cnt) + 10'h001));
   endproperty
   a_step: assert property (p_step) else $error("counter did not step by one");

   property p_ext_edge;
      (s_r.timer_control_0.run && s_r.timer_control_0.counter_clock_select == CS_EXT
       && !s_r.timer_control_0.edge_fall && !s_r.ext_prev && timer_ext_clock_pin)
      |=> (s_r.cnt != $past(s_r.cnt) || s_r.cnt == '0);
   endproperty
   a_ext_edge: assert property (p_ext_edge) else $error("rising edge not counted");

   property p_match_flag;
      (tick && s_r.cnt == s_r.comparator_a_value) |=> s_r.istat[IRQ_A] ##1 (irq || !s_r.imask[IRQ_A] || !s_r.istat[IRQ_A]);
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match A flag missing");

   property p_irq_level;
      ##1 (irq == |(s_r.istat & s_r.imask));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq disagrees with flags");

   property p_toggle;
      (s_r.ctrl1.mode == MODE_CMP && s_r.ctrl1.out_act == ACT_TOGGLE && match_a)
      |=> (s_r.tm_out != $past(s_r.tm_out));
   endproperty
   a_toggle: assert property (p_toggle) else $error("output did not toggle");

   property p_pwm;
      (s_r.ctrl1.mode == MODE_PWM) |=> (s_r.tm_out == ($past(s_r.cnt) < $past(duty)));
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm level wrong");

   property p_pin_alt;
      (!s_r.timer_pin_enable_0[0]) |=> (timer_output_pin[0] == $past(alt_func_out[0]));
   endproperty
   a_pin_alt: assert property (p_pin_alt) else $error("disabled pin not on alternate");

   property p_wr_low_buf;
      (acc_wr && paddr == OFF_CMPA_L)
      |=> (s_r.comparator_a_value == $past(s_r.comparator_a_value)
           && s_r.cmpa_buf == $past(pwdata[7:0]));
   endproperty
   a_wr_low_buf: assert property (p_wr_low_buf) else $error("low write reached register");

   property p_rd_hi_latch;
      (acc_rd && paddr == OFF_CNT_H) |=> (s_r.cnt_buf == $past(s_r.cnt[7:0]));
   endproperty
   a_rd_hi_latch: assert property (p_rd_hi_latch) else $error("high read did not latch");

   property p_wr_hi_commit;
      (acc_wr && paddr == OFF_CMPA_H)
      |=> (s_r.comparator_a_value == {$past(pwdata[HI_W-1:0]), $past(s_r.cmpa_buf)});
   endproperty
   a_wr_hi_commit: assert property (p_wr_hi_commit) else $error("high write lost");

   property p_stop_holds;
      (!s_r.timer_control_0.run) |=> (s_r.cnt == $past(s_r.cnt));
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

   property p_clear;
      (tick && clr_hit) |=> (s_r.cnt == '0);
   endproperty
   a_clear: assert property (p_clear) else $error("match did not clear counter");

   property p_ext_owned;
      (s_r.timer_control_0.counter_clock_select == CS_EXT) |=> !ext_pin_alt;
   endproperty
   a_ext_owned: assert property (p_ext_owned) else $error("owned pin leaked");

   property p_ext_pass;
      (s_r.timer_control_0.counter_clock_select != CS_EXT)
      |=> (ext_pin_alt == $past(timer_ext_clock_pin));
   endproperty
   a_ext_pass: assert property (p_ext_pass) else $error("pin not passed on");

   property p_fall_edge;
      (s_r.timer_control_0.run && s_r.timer_control_0.counter_clock_select == CS_EXT
       && s_r.timer_control_0.edge_fall && s_r.ext_prev && !timer_ext_clock_pin)
      |=> (s_r.cnt != $past(s_r.cnt) || s_r.cnt == '0);
   endproperty
   a_fall_edge: assert property (p_fall_edge) else $error("falling edge not counted");

   property p_ext_idle;
      (s_r.timer_control_0.counter_clock_select == CS_EXT
       && s_r.ext_prev == timer_ext_clock_pin) |=> (s_r.cnt == $past(s_r.cnt));
   endproperty
   a_ext_idle: assert property (p_ext_idle) else $error("counted without pin edge");

   property p_match_b;
      (tick && s_r.cnt == s_r.comparator_b_value) |=> s_r.istat[IRQ_B];
   endproperty
   a_match_b: assert property (p_match_b) else $error("match B flag missing");

   property p_match_p;
      (tick && s_r.cnt == s_r.ccrp) |=> s_r.istat[IRQ_P];
   endproperty
   a_match_p: assert property (p_match_p) else $error("match P flag missing");

   property p_set_high;
      (s_r.ctrl1.mode == MODE_CMP && s_r.ctrl1.out_act == ACT_HIGH && match_a) |=> s_r.tm_out;
   endproperty
   a_set_high: assert property (p_set_high) else $error("output not driven high");

   property p_set_low;
      (s_r.ctrl1.mode == MODE_CMP && s_r.ctrl1.out_act == ACT_LOW && match_a) |=> !s_r.tm_out;
   endproperty
   a_set_low: assert property (p_set_low) else $error("output not driven low");

   property p_pin_timer;
      (s_r.timer_pin_enable_0[0])
      |=> (timer_output_pin[0] == ($past(s_r.tm_out) ^ ~$past(s_r.port_data[0])));
   endproperty
   a_pin_timer: assert property (p_pin_timer) else $error("owned pin level wrong");

endmodule

// file: tmc_far_side.sv
// Far-side model: external clock/event source and alternate pin functions.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/100ps
module tmc_far_side (
   input  wire logic       pclk,
   output logic            ext_pin,
   output logic [1:0]      alt_out
);
   initial begin
      ext_pin = 1'b0;
      alt_out = 2'h2;
   end

   // Level held several cycles so the one-cycle edge detector sees it
   task automatic drive(input logic lvl, input int hold);
      @(posedge pclk);
      ext_pin <= lvl;
      repeat (hold) @(posedge pclk);
   endtask

   // Event clock stands low between bursts
   task automatic pulses(input int n);
      repeat (n) begin
         drive(1'b1, 2);
         drive(1'b0, 2);
      end
   endtask

   task automatic set_alt(input logic [1:0] v);
      @(posedge pclk);
      alt_out <= v;
   endtask
endmodule

// file: tmc_pkg.sv
// Shared constants, register map and carrier types for the timer core.
// Assumes a single 10 MHz pclk domain and an APB register bus.
package tmc_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int CNT_W = 10;
   localparam int HI_W  = CNT_W - 8;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL0  = 8'h00;
   localparam logic [7:0] OFF_CTRL1  = 8'h04;
   localparam logic [7:0] OFF_CNT_L  = 8'h08;
   localparam logic [7:0] OFF_CNT_H  = 8'h0c;
   localparam logic [7:0] OFF_CMPA_L = 8'h10;
   localparam logic [7:0] OFF_CMPA_H = 8'h14;
   localparam logic [7:0] OFF_CMPB_L = 8'h18;
   localparam logic [7:0] OFF_CMPB_H = 8'h1c;
   localparam logic [7:0] OFF_CCRP_L = 8'h20;
   localparam logic [7:0] OFF_CCRP_H = 8'h24;
   localparam logic [7:0] OFF_PINEN  = 8'h28;
   localparam logic [7:0] OFF_PDATA  = 8'h2c;
   localparam logic [7:0] OFF_ISTAT  = 8'h30;
   localparam logic [7:0] OFF_IMASK  = 8'h34;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] PINEN_RST = 2'h1;
   localparam logic [1:0] PDATA_RST = 2'h3;

   // ----------------------------------------------------------------
   // Interrupt bit positions
   // ----------------------------------------------------------------
   localparam int IRQ_A = 0;
   localparam int IRQ_B = 1;
   localparam int IRQ_P = 2;

   // ----------------------------------------------------------------
   // Prescaler terminal counts
   // ----------------------------------------------------------------
   localparam logic [1:0] SYS_DIV4_TC  = 2'h3;
   localparam logic [1:0] HI_DIV4_TC   = 2'h3;
   localparam logic [3:0] HI_DIV16_TC  = 4'hf;
   localparam logic [5:0] HI_DIV64_TC  = 6'h3f;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CS_SYS_DIV4  = 3'b000,
      CS_SYS       = 3'b001,
      CS_HI_DIV16  = 3'b010,
      CS_HI_DIV64  = 3'b011,
      CS_TBC       = 3'b100,
      CS_RSVD      = 3'b101,
      CS_EXT       = 3'b110,
      CS_HI_DIV4   = 3'b111
   } tmc_clk_sel_t;

   typedef enum logic [1:0] {
      MODE_CMP   = 2'b00,
      MODE_TIMER = 2'b01,
      MODE_PWM   = 2'b10,
      MODE_IDLE  = 2'b11
   } tmc_mode_t;

   typedef enum logic [1:0] {
      ACT_NONE   = 2'b00,
      ACT_LOW    = 2'b01,
      ACT_HIGH   = 2'b10,
      ACT_TOGGLE = 2'b11
   } tmc_out_act_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic         edge_fall;
      tmc_clk_sel_t counter_clock_select;
      logic         run;
   } tmc_ctrl0_t;

   typedef struct packed {
      logic         pwm_adj_period;
      logic         clr_on_a;
      tmc_mode_t    mode;
      tmc_out_act_t out_act;
   } tmc_ctrl1_t;

   typedef struct packed {
      logic sys_div4;
      logic hi_div4;
      logic hi_div16;
      logic hi_div64;
   } tmc_ticks_t;

   typedef struct packed {
      logic [1:0] sys_cnt;
      logic [5:0] hi_cnt;
   } tmc_pre_state_t;

   typedef struct packed {
      tmc_ctrl0_t       timer_control_0;
      tmc_ctrl1_t       ctrl1;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] comparator_a_value;
      logic [CNT_W-1:0] comparator_b_value;
      logic [CNT_W-1:0] ccrp;
      logic [7:0]       cnt_buf;
      logic [7:0]       cmpa_buf;
      logic [7:0]       cmpb_buf;
      logic [7:0]       ccrp_buf;
      logic [1:0]       timer_pin_enable_0;
      logic [1:0]       port_data;
      logic [2:0]       istat;
      logic [2:0]       imask;
      logic             irq;
      logic             tm_out;
      logic [1:0]       pin_out;
      logic             ext_prev;
      logic             ext_alt;
      logic [7:0]       rdata;
   } tmc_state_t;

endpackage

// file: tmc_prescaler.sv
// Divider that turns pclk and the internal high clock tick into enables.
// Assumes high_tick is a one-cycle pulse synchronous to pclk.
`timescale 1ns/100ps
module tmc_prescaler
   import tmc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       high_tick,
   output tmc_ticks_t      ticks
);

   tmc_pre_state_t s_r;
   tmc_pre_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.sys_cnt = 2'(s_r.sys_cnt + 2'h1);
      if (high_tick) begin
         s_nxt.hi_cnt = 6'(s_r.hi_cnt + 6'h01);
      end
      ticks.sys_div4 = (s_r.sys_cnt == SYS_DIV4_TC);
      ticks.hi_div4  = high_tick & (s_r.hi_cnt[1:0] == HI_DIV4_TC);
      ticks.hi_div16 = high_tick & (s_r.hi_cnt[3:0] == HI_DIV16_TC);
      ticks.hi_div64 = high_tick & (s_r.hi_cnt == HI_DIV64_TC);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule
